// >>> common/drive_pkg.sv
// Purpose: Shared constants and carrier types for the drive select/status block
// Assumes: 100 MHz system clock
// Notes: Times are kept in their own units; cycle counts derive from them
package drive_pkg;
  // Clock rate
  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  // Select must complete within this time
  localparam int SEL_MAX_NS = 600;
  // Hold line noise filter, least time
  localparam int HOLD_FILT_MS = 10;
  localparam int HOLD_FILT_CYC = HOLD_FILT_MS * 1000 * CYC_PER_US;
  // Spindle must be at speed within this time
  localparam longint SPIN_UP_S = 120;
  localparam longint SPIN_UP_CYC = SPIN_UP_S * longint'(CLK_HZ);
  // Spindle stop limit, enforced by the motor drive itself
  localparam int SPIN_STOP_S = 60;
  // Zero-length seek, same head: seek end low at most this long
  localparam int SAME_SEEK_US = 1500;
  localparam int SAME_SEEK_CYC = SAME_SEEK_US * CYC_PER_US;
  // Zero-length seek with head change
  localparam int HEAD_SEEK_MS = 10;
  localparam int HEAD_SEEK_CYC = HEAD_SEEK_MS * 1000 * CYC_PER_US;
  // Illegal cylinder: seek error raised after this time
  localparam int ILL_SEEK_US = 1500;
  localparam int ILL_SEEK_CYC = ILL_SEEK_US * CYC_PER_US;
  // Settle time for a real head move
  localparam int MOVE_SEEK_MS = 20;
  localparam int MOVE_SEEK_CYC = MOVE_SEEK_MS * 1000 * CYC_PER_US;
  // Highest legal cylinder
  localparam logic [7:0] MAX_CYL = 8'hcd;
  // Servo clock periods allowed for read lock
  localparam logic [6:0] RD_LOCK_CLKS = 7'h58;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SEEK = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  // Control register bits
  localparam int CT_PANEL_START = 0;
  localparam int CT_MAINT = 1;
  localparam int CT_DC_OK = 2;
  localparam int CT_AC_OK = 3;
  localparam int CT_PROT_FIXED = 4;
  localparam int CT_PROT_REM = 5;
  localparam int CT_VOL_REM = 6;
  localparam int CT_FAULT_CLR = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  // Seek register fields
  localparam int SK_HEAD_CHG = 8;
  localparam int SK_RTZ = 9;
  // Status register bits
  localparam int ST_SELECTED = 0;
  localparam int ST_HOLD = 1;
  localparam int ST_MOTOR = 2;
  localparam int ST_SPEED = 3;
  localparam int ST_READY = 4;
  localparam int ST_ONCYL = 5;
  localparam int ST_SEEKERR = 6;
  localparam int ST_FAULT = 7;
  localparam int ST_RDLOCK = 8;
  localparam int ST_CABLE = 9;
  localparam int ST_SPINFAIL = 10;
  // Seek sequencer states
  typedef enum logic [1:0] {
    SK_IDLE = 2'b01,
    SK_BUSY = 2'b10
  } seek_st_t;
  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
  // Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage

// >>> src/drive_select_status.sv
// Purpose: Drive side of the select, status, spindle and data lines
// Assumes: Cable and drive pins are asynchronous to clk_i and pass two flip-flops; chain lines pass straight through
// Notes: Registers sit on a classic Wishbone slave, one ack per request
// What this block does
// - Ready only when selected, at speed, on track
// - Lost A cable disables A side only; here it also deselects, dropping unit selected and seek end
// - Select completes within 600 ns of tag
// - Four select lines match switch unit number
// - Address mark found output always zero
// - Protect shows status; write gate then faults
// - Pick and busy only chained through
// - Hold low starts spindle given power, panel
// - Speed within 120 s, shown through ready
// - Hold release drops ready, stops spindle
// - Hold changes under 10 ms are ignored
// - Panel switch needs hold, unless maintenance
// - Unit selected high on match at tag
// - Seek end is on cylinder or error
// - Zero seek: 1.5 ms or 10 ms low
// - Cylinder above 205 gives error within 3 ms
// - Servo clock runs free, never select-gated
// - Read data NRZ, aligned to read clock
// - Read clock locks within 88 servo periods
// - Seek drops on cylinder until on track
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module drive_select_status
  import drive_pkg::*;
#(
  parameter int FILT_CYC = HOLD_FILT_CYC,
  parameter longint SPIN_CYC = SPIN_UP_CYC,
  parameter int SAME_CYC = SAME_SEEK_CYC,
  parameter int HEAD_CYC = HEAD_SEEK_CYC,
  parameter int ILL_CYC = ILL_SEEK_CYC,
  parameter int MOVE_CYC = MOVE_SEEK_CYC
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire wb_req_t wb_i,
  output wb_rsp_t wb_o,
  // A cable inputs
  input wire logic sel_tag_i,
  input wire logic [3:0] unit_sel_i,
  input wire logic cable_ok_i,
  input wire logic hold_n_i,
  input wire logic write_gate_i,
  input wire logic read_gate_i,
  // A cable outputs
  output logic ready_o,
  output logic write_prot_o,
  output logic fault_o,
  output logic on_cyl_o,
  output logic seek_err_o,
  output logic amf_o,
  // Daisy chain lines
  input wire logic pick_i,
  output logic pick_o,
  input wire logic busy_i,
  output logic busy_o,
  input wire logic amf_chain_i,
  output logic amf_chain_o,
  // B cable lines
  output logic unit_selected_o,
  output logic seek_end_o,
  input wire logic write_data_i,
  input wire logic write_clk_i,
  output logic servo_clk_o,
  output logic read_data_o,
  output logic read_clk_o,
  // Drive internals
  input wire logic [3:0] unit_sw_i,
  input wire logic plo_servo_clk_i,
  input wire logic sep_read_clk_i,
  input wire logic sep_read_data_i,
  input wire logic at_speed_i,
  output logic motor_run_o,
  output logic head_write_o,
  output logic head_write_en_o
);

  // Refuse counts the timers cannot hold
  if (FILT_CYC < 1 || FILT_CYC >= 2**24 || SAME_CYC < 1 || SAME_CYC >= 2**24 || HEAD_CYC < 1
      || HEAD_CYC >= 2**24 || ILL_CYC < 1 || ILL_CYC >= 2**24 || MOVE_CYC < 1
      || MOVE_CYC >= 2**24 || SPIN_CYC < 1 || SPIN_CYC >= 64'h10_0000_0000)
  begin : bad_param
    $error("drive_select_status: timer parameter out of range");
  end

  // Synchroniser width and pin positions
  localparam int NSYNC = 19;
  localparam int P_TAG = 0;
  localparam int P_UNIT = 1;
  localparam int P_CABLE = 5;
  localparam int P_HOLDN = 6;
  localparam int P_WG = 7;
  localparam int P_RG = 8;
  localparam int P_SERVO = 9;
  localparam int P_RCLK = 10;
  localparam int P_RDAT = 11;
  localparam int P_WCLK = 12;
  localparam int P_WDAT = 13;
  localparam int P_SPEED = 14;
  localparam int P_SW = 15;

  // All state of the block
  typedef struct packed {
    logic [NSYNC-1:0] s1; // First sync stage, read only by s2
    logic [NSYNC-1:0] s2; // Second sync stage
    logic [NSYNC-1:0] s3; // Previous s2, for edges
    logic selected;
    logic hold; // Filtered hold, high when asserted
    logic [23:0] filt_cnt;
    logic motor;
    logic [35:0] spin_cnt;
    logic spin_fail;
    logic [6:0] ctrl;
    logic fault;
    seek_st_t sk;
    logic [23:0] sk_cnt;
    logic sk_ill;
    logic on_cyl;
    logic seek_err;
    logic [7:0] cyl;
    logic [6:0] lock_cnt;
    logic rd_lock;
    logic rclk;
    logic rdat;
    logic wbit;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;
  logic [NSYNC-1:0] pins; // Raw asynchronous inputs
  logic [NSYNC-1:0] rise; // Rising edges after sync
  logic cable; // A cable present
  logic hold_raw; // Synchronised hold, active high
  logic run_ok; // Spindle allowed to turn
  logic ready; // Ungated ready
  logic protect; // Selected volume is protected
  logic wr_req; // Register write taken
  logic [31:0] stat_word; // Status register image

  // Gather pins for the synchroniser
  assign pins = {unit_sw_i, at_speed_i, write_data_i, write_clk_i,
                 sep_read_data_i, sep_read_clk_i, plo_servo_clk_i,
                 read_gate_i, write_gate_i, hold_n_i, cable_ok_i,
                 unit_sel_i, sel_tag_i};
  assign rise = st.s2 & ~st.s3;
  assign cable = st.s2[P_CABLE];
  assign hold_raw = ~st.s2[P_HOLDN];
  assign protect = st.ctrl[CT_VOL_REM] ? st.ctrl[CT_PROT_REM] : st.ctrl[CT_PROT_FIXED];
  assign wr_req = wb_i.cyc && wb_i.stb && wb_i.we && !st.ack;
  // Ready reflects the spindle only while hold is in force
  assign ready = st.motor && st.hold && st.s2[P_SPEED] && st.on_cyl;
  // Panel needs hold unless the maintenance switch overrides
  assign run_ok = st.ctrl[CT_DC_OK] && st.ctrl[CT_AC_OK] && st.ctrl[CT_PANEL_START]
                  && (st.hold || st.ctrl[CT_MAINT]);

  // Status image for reads
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[ST_SELECTED] = st.selected;
    stat_word[ST_HOLD] = st.hold;
    stat_word[ST_MOTOR] = st.motor;
    stat_word[ST_SPEED] = st.s2[P_SPEED];
    stat_word[ST_READY] = ready;
    stat_word[ST_ONCYL] = st.on_cyl;
    stat_word[ST_SEEKERR] = st.seek_err;
    stat_word[ST_FAULT] = st.fault;
    stat_word[ST_RDLOCK] = st.rd_lock;
    stat_word[ST_CABLE] = cable;
    stat_word[ST_SPINFAIL] = st.spin_fail;
  end

  // Next-state logic for the whole block
  always_comb
  begin
    next_st = st;
    // Two-stage synchroniser and edge history
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;

    // Tag edge samples the code; match selects, mismatch deselects
    if (!cable)
    begin
      next_st.selected = 1'b0;
    end
    else if (rise[P_TAG])
    begin
      // Edge seen two cycles after the pin, selected on the third, well inside the limit
      next_st.selected = (st.s2[P_UNIT +: 4] == st.s2[P_SW +: 4]);
    end

    // Hold filter: a level must stand for the full window
    if (!cable || hold_raw == st.hold)
    begin
      next_st.filt_cnt = '0;
      if (!cable)
      begin
        // No controller: treat hold as released
        next_st.hold = 1'b0;
      end
    end
    else if (st.filt_cnt == 24'(FILT_CYC - 1))
    begin
      next_st.hold = hold_raw;
      next_st.filt_cnt = '0;
    end
    else
    begin
      next_st.filt_cnt = st.filt_cnt + 24'h000001;
    end

    // Spindle drive and spin-up watch
    next_st.motor = run_ok;
    if (!st.motor || st.s2[P_SPEED])
    begin
      next_st.spin_cnt = '0;
    end
    else if (st.spin_cnt == 36'(SPIN_CYC - 1))
    begin
      // Missed the spin-up limit; flag it, motor keeps trying
      next_st.spin_fail = 1'b1;
    end
    else
    begin
      next_st.spin_cnt = st.spin_cnt + 36'h000000001;
    end

    // Write gate on a protected volume faults; set beats clear
    if (wr_req && wb_i.adr == REG_CTRL && wb_i.sel[0])
    begin
      next_st.ctrl = wb_i.dat[6:0];
      if (wb_i.dat[CT_FAULT_CLR])
      begin
        next_st.fault = 1'b0;
      end
    end
    if (cable && st.selected && st.s2[P_WG] && protect)
    begin
      next_st.fault = 1'b1;
    end

    // Seek sequencer
    unique case (st.sk)
      SK_IDLE:
      begin
        if (wr_req && wb_i.adr == REG_SEEK && wb_i.sel[1:0] == 2'b11)
        begin
          next_st.on_cyl = 1'b0;
          next_st.sk = SK_BUSY;
          next_st.sk_ill = 1'b0;
          if (wb_i.dat[SK_RTZ])
          begin
            // Return to zero clears the error
            next_st.seek_err = 1'b0;
            next_st.cyl = 8'h00;
            next_st.sk_cnt = 24'(MOVE_CYC - 1);
          end
          else if (st.seek_err)
          begin
            // No motion until a return to zero
            next_st.sk_ill = 1'b1;
            next_st.sk_cnt = 24'(ILL_CYC - 1);
          end
          else if (wb_i.dat[7:0] > MAX_CYL)
          begin
            next_st.sk_ill = 1'b1;
            next_st.sk_cnt = 24'(ILL_CYC - 1);
          end
          else if (wb_i.dat[7:0] == st.cyl)
          begin
            // Zero-length seek, with or without head change
            next_st.sk_cnt = wb_i.dat[SK_HEAD_CHG] ? 24'(HEAD_CYC - 1)
                                                   : 24'(SAME_CYC - 1);
          end
          else
          begin
            next_st.cyl = wb_i.dat[7:0];
            next_st.sk_cnt = 24'(MOVE_CYC - 1);
          end
        end
      end
      SK_BUSY:
      begin
        if (st.sk_cnt == 24'h000000)
        begin
          next_st.sk = SK_IDLE;
          if (st.sk_ill)
          begin
            next_st.seek_err = 1'b1;
          end
          else
          begin
            next_st.on_cyl = 1'b1;
          end
        end
        else
        begin
          next_st.sk_cnt = st.sk_cnt - 24'h000001;
        end
      end
    endcase

    // Read lock: count servo periods while read gate is on
    if (!st.s2[P_RG])
    begin
      next_st.lock_cnt = '0;
      next_st.rd_lock = 1'b0;
    end
    else if (rise[P_SERVO] && !st.rd_lock)
    begin
      if (st.lock_cnt == RD_LOCK_CLKS - 7'h01)
      begin
        next_st.rd_lock = 1'b1;
      end
      else
      begin
        next_st.lock_cnt = st.lock_cnt + 7'h01;
      end
    end

    // Read clock and data leave together, data held per cell
    next_st.rclk = st.s2[P_RCLK];
    if (rise[P_RCLK])
    begin
      next_st.rdat = st.s2[P_RDAT];
    end
    // Write data taken on the returned write clock
    if (rise[P_WCLK])
    begin
      next_st.wbit = st.s2[P_WDAT];
    end

    // Bus slave: one ack per request, dropped next cycle
    next_st.ack = wb_i.cyc && wb_i.stb && !st.ack;
    next_st.rdata = 32'h0000_0000;
    if (wb_i.cyc && wb_i.stb && !wb_i.we && !st.ack)
    begin
      unique case (wb_i.adr)
        REG_CTRL: next_st.rdata = {25'h0000000, st.ctrl};
        REG_SEEK: next_st.rdata = {24'h000000, st.cyl};
        REG_STAT: next_st.rdata = stat_word;
        default: next_st.rdata = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.s1 <= '1; // Hold pin idles high
      st.s2 <= '1;
      st.s3 <= '1;
      st.ctrl <= CTRL_RESET;
      st.sk <= SK_IDLE;
      st.on_cyl <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Bus answer
  assign wb_o.ack = st.ack;
  assign wb_o.dat = st.rdata;

  // A cable status, gated by selection and cable presence
  assign ready_o = cable && st.selected && ready;
  assign write_prot_o = cable && st.selected && protect;
  assign fault_o = cable && st.selected && st.fault;
  assign on_cyl_o = cable && st.selected && st.on_cyl;
  assign seek_err_o = cable && st.selected && st.seek_err;
  assign amf_o = 1'b0;

  // Chain lines pass straight through, uninterpreted
  assign pick_o = pick_i;
  assign busy_o = busy_i;
  assign amf_chain_o = amf_chain_i;

  // B cable clocks and read data stay live with the A cable gone; unit selected and seek end drop
  assign unit_selected_o = st.selected;
  assign seek_end_o = st.selected && (st.on_cyl || st.seek_err);
  assign servo_clk_o = st.s3[P_SERVO];
  assign read_clk_o = st.rclk;
  assign read_data_o = st.rdat;

  // Drive internals
  assign motor_run_o = st.motor;
  assign head_write_o = st.wbit;
  assign head_write_en_o = cable && st.selected && st.s2[P_WG] && !protect
                           && st.on_cyl && !st.fault;

endmodule // drive_select_status

// >>> test/ctrl_model.sv
// Purpose: Controller model on the select, hold and write lines
// Assumes: Bench calls its tasks one at a time
// Notes: Write clock only echoes the servo clock while writing
`timescale 1ns/1ps
module ctrl_model (
  // Clocks
  input wire logic clk_i,
  input wire logic servo_clk_i,
  // Cable lines
  output logic sel_tag_o = 1'b0,
  output logic [3:0] unit_sel_o = 4'h0,
  output logic hold_n_o = 1'b1,
  output logic write_gate_o = 1'b0,
  output logic write_clk_o,
  output logic write_data_o = 1'b0
);
  logic wclk_en = 1'b0; // Echo enable
  // Returned clock, stands still outside writes
  // Echoing each servo edge makes the count jitter between sectors harmless
  assign write_clk_o = servo_clk_i & wclk_en;
  // NRZ data changes off the clock edge it rides with
  always @(negedge servo_clk_i)
    write_data_o <= ~write_data_o;
  // Code valid before tag rise; line scrambled afterwards
  task sel(input logic [3:0] c);
    @(posedge clk_i);
    unit_sel_o <= c;
    repeat (4) @(posedge clk_i);
    sel_tag_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    sel_tag_o <= 1'b0;
    unit_sel_o <= ~c;
  endtask
  // Hold level for a number of cycles
  task hold_for(input logic lvl, input int n);
    @(posedge clk_i);
    hold_n_o <= lvl;
    repeat (n) @(posedge clk_i);
  endtask
  // Clock leads write gate by over 250 ns
  task wr(input logic on);
    @(posedge clk_i);
    if (on)
    begin
      wclk_en <= 1'b1;
      repeat (30) @(posedge clk_i);
    end
    write_gate_o <= on;
    @(posedge clk_i);
    wclk_en <= on;
  endtask
endmodule // ctrl_model

// >>> test/disk_drive_select_status_lines_tb_top.sv
// Purpose: Self-checking bench for the drive select/status block
// Assumes: Short parameter values stand in for long counts
// Notes: Seed fixed so runs repeat
`timescale 1ns/1ps
module disk_drive_select_status_lines_tb_top import drive_pkg::*; ();
  localparam int SAME = 15, HEAD = 30, ILL = 10; // Scaled seek counts
  logic clk_i = 1'b0, rst_i = 1'b1;
  wb_req_t wb_i = '0;
  wb_rsp_t wb_o;
  logic cab = 1'b1, rgate = 1'b0, pk = 1'b0, bz = 1'b0, am = 1'b0, spd = 1'b0;
  logic phase_locked_oscillator = 1'b0, srclk = 1'b0, srdat = 1'b0;
  logic [3:0] sw = 4'h0, code;
  logic [31:0] q;
  int t, err_count = 0, n_checks = 0;
  wire tag, hold_n, wg, wclk, wdat, sclk;
  wire [3:0] usel;
  wire rdy, wp, flt, oc, serr, usd, send, mot;
  // Clocks: system and free-running link clocks
  always #5 clk_i = ~clk_i;
  always #62.5 phase_locked_oscillator = ~phase_locked_oscillator;
  always #58 srclk = ~srclk;
  // Random chain and read data traffic
  always @(posedge clk_i) {pk, bz, am, srdat} <= 4'($urandom);
  ctrl_model u_ctrl (.clk_i(clk_i), .servo_clk_i(sclk), .sel_tag_o(tag), .unit_sel_o(usel),
    .hold_n_o(hold_n), .write_gate_o(wg), .write_clk_o(wclk), .write_data_o(wdat));
  drive_select_status #(.FILT_CYC(20), .SPIN_CYC(200), .SAME_CYC(SAME), .HEAD_CYC(HEAD),
    .ILL_CYC(ILL), .MOVE_CYC(40)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
    .wb_o(wb_o), .sel_tag_i(tag), .unit_sel_i(usel), .cable_ok_i(cab), .hold_n_i(hold_n),
    .write_gate_i(wg), .read_gate_i(rgate), .ready_o(rdy), .write_prot_o(wp),
    .fault_o(flt), .on_cyl_o(oc), .seek_err_o(serr), .amf_o(), .pick_i(pk), .pick_o(),
    .busy_i(bz), .busy_o(), .amf_chain_i(am), .amf_chain_o(), .unit_selected_o(usd),
    .seek_end_o(send), .write_data_i(wdat), .write_clk_i(wclk), .servo_clk_o(sclk),
    .read_data_o(), .read_clk_o(), .unit_sw_i(sw), .plo_servo_clk_i(phase_locked_oscillator),
    .sep_read_clk_i(srclk), .sep_read_data_i(srdat), .at_speed_i(spd),
    .motor_run_o(mot), .head_write_o(), .head_write_en_o());
  // Verdict and end of run
  task test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      $display("unexpected %s exp %b got %b", nm, e, g);
      err_count++;
    end
  endtask
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask
  // One classic cycle; request held until ack is sampled
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, we, a, 4'hf, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_o.ack !== 1'b1 && n < 40);
    q = wb_o.dat;
    wb_i <= '0;
    if (wb_o.ack !== 1'b1)
    begin
      err_count++;
      test_done();
    end
  endtask
  function logic get(input int k);
    case (k)
      0: return mot;
      1: return send;
      default: return flt;
    endcase
  endfunction
  // Bounded wait; t returns the cycles spent
  task wt(input int k, input logic v, input int lim);
    t = 0;
    while (get(k) !== v && t < lim)
    begin
      @(posedge clk_i);
      t++;
    end
    if (get(k) !== v)
    begin
      $display("unexpected wait %0d exp %b got %b", k, v, get(k));
      err_count++;
      test_done();
    end
  endtask
  // Seek and time the seek end low phase
  task seek(input logic [31:0] d, input int lim);
    wb(1'b1, REG_SEEK, d);
    chk_bit("seek_end drop", 1'b0, send);
    wt(1, 1'b1, 100);
    chk_bit("seek time", 1'b1, logic'(t <= lim + 4));
  endtask
  // Watchdog
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_count++;
    test_done();
  end
  // Main sequence
  initial
  begin
    void'($urandom(90));
    sw = 4'($urandom);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h0c, 32'h0);
    chk_word("unmapped", 32'h0, q);
    // Matching, mismatching and random codes
    for (int i = 0; i < 8; i++)
    begin
      code = (i == 0) ? sw : (i == 1) ? ~sw : 4'($urandom);
      u_ctrl.sel(code);
      chk_bit("unit_selected", code == sw, usd);
    end
    u_ctrl.sel(sw);
    chk_bit("seek_end", 1'b1, send);
    wb(1'b1, REG_CTRL, 32'h0d);
    u_ctrl.hold_for(1'b0, 10);
    u_ctrl.hold_for(1'b1, 40);
    chk_bit("motor glitch", 1'b0, mot);
    u_ctrl.hold_for(1'b0, 30);
    chk_bit("motor", 1'b1, mot);
    // Motor on but never at speed: spin-up watch must flag it
    repeat (210) @(posedge clk_i);
    wb(1'b0, REG_STAT, 32'h0);
    chk_bit("spin fail", 1'b1, q[ST_SPINFAIL]);
    wb(1'b1, REG_CTRL, 32'h0c);
    wt(0, 1'b0, 5);
    wb(1'b1, REG_CTRL, 32'h0d);
    spd <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk_bit("ready", 1'b1, rdy);
    u_ctrl.sel(~sw);
    chk_bit("ready desel", 1'b0, rdy);
    u_ctrl.sel(sw);
    seek(32'h0, SAME);
    seek(32'h100, HEAD);
    seek(32'hce, ILL);
    chk_bit("seek_err", 1'b1, serr);
    wb(1'b1, REG_SEEK, 32'h200);
    wt(1, 1'b1, 100);
    chk_bit("seek_err rtz", 1'b0, serr);
    wb(1'b1, REG_CTRL, 32'h1d);
    chk_bit("write_prot", 1'b1, wp);
    u_ctrl.wr(1'b1);
    wt(2, 1'b1, 10);
    u_ctrl.wr(1'b0);
    wb(1'b1, REG_CTRL, 32'h8d);
    wt(2, 1'b0, 10);
    wb(1'b0, REG_CTRL, 32'h0);
    chk_word("ctrl", 32'h0d, q);
    rgate <= 1'b1;
    repeat (1200) @(posedge clk_i);
    wb(1'b0, REG_STAT, 32'h0);
    chk_bit("read lock", 1'b1, q[ST_RDLOCK]);
    cab <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk_bit("ready cable", 1'b0, rdy);
    cab <= 1'b1;
    u_ctrl.sel(sw);
    u_ctrl.hold_for(1'b1, 30);
    chk_bit("ready hold off", 1'b0, rdy);
    chk_bit("motor hold off", 1'b0, mot);
    test_done();
  end
endmodule // disk_drive_select_status_lines_tb_top

// >>> test/drive_select_status_monitor.sv
// Purpose: Port checker for the drive select/status block
// Assumes: One clock domain, reset synchronous
// Notes: Windows allow for the two-flop pin syncs
`timescale 1ns/1ps
module drive_select_status_monitor #(
  parameter int FILT_CYC = 20
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched lines
  input wire logic sel_tag_i,
  input wire logic [3:0] unit_sel_i,
  input wire logic [3:0] unit_sw_i,
  input wire logic cable_ok_i,
  input wire logic hold_n_i,
  input wire logic write_gate_i,
  input wire logic pick_i,
  input wire logic pick_o,
  input wire logic busy_i,
  input wire logic busy_o,
  input wire logic amf_o,
  input wire logic ready_o,
  input wire logic write_prot_o,
  input wire logic fault_o,
  input wire logic on_cyl_o,
  input wire logic seek_end_o,
  input wire logic unit_selected_o,
  input wire logic motor_run_o,
  input wire logic plo_servo_clk_i,
  input wire logic servo_clk_o,
  input wire logic sep_read_clk_i,
  input wire logic read_clk_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int hcnt; // Cycles the hold line has been released
  // Saturating count keeps the compare cheap
  always_ff @(posedge clk_i)
    hcnt <= (rst_i || !hold_n_i) ? 0 : (hcnt < 1000 ? hcnt + 1 : hcnt);
  // Tag edge with matching or foreign code
  sequence s_tag(logic m);
    $rose(sel_tag_i) && cable_ok_i && ((unit_sel_i == unit_sw_i) == m);
  endsequence
  property p_sel; s_tag(1'b1) |-> ##[1:60] unit_selected_o; endproperty
  a_sel: assert property (p_sel) else $error("select late");
  property p_desel; s_tag(1'b0) |-> ##[1:60] !unit_selected_o; endproperty
  a_desel: assert property (p_desel) else $error("deselect late");
  property p_amf; amf_o == 1'b0; endproperty
  a_amf: assert property (p_amf) else $error("mark line driven");
  property p_chain; pick_o == pick_i && busy_o == busy_i; endproperty
  a_chain: assert property (p_chain) else $error("chain broken");
  property p_ready; ready_o |-> unit_selected_o && on_cyl_o && motor_run_o; endproperty
  a_ready: assert property (p_ready) else $error("ready unqualified");
  property p_cable; (!cable_ok_i)[*5] |-> !ready_o && !fault_o && !write_prot_o; endproperty
  a_cable: assert property (p_cable) else $error("A side not disabled");
  property p_send; unit_selected_o && on_cyl_o |-> seek_end_o; endproperty
  a_send: assert property (p_send) else $error("seek end low");
  property p_prot; (write_gate_i && write_prot_o)[*4] |-> ##[0:4] fault_o; endproperty
  a_prot: assert property (p_prot) else $error("no protect fault");
  property p_servo; $rose(plo_servo_clk_i) |-> ##3 servo_clk_o; endproperty
  a_servo: assert property (p_servo) else $error("servo clock gated");
  property p_rclk; $rose(sep_read_clk_i) |-> ##3 read_clk_o; endproperty
  a_rclk: assert property (p_rclk) else $error("read clock lost");
  property p_hold; hcnt > FILT_CYC + 8 |-> !ready_o; endproperty
  a_hold: assert property (p_hold) else $error("ready after hold off");
endmodule // drive_select_status_monitor
bind drive_select_status drive_select_status_monitor #(.FILT_CYC(FILT_CYC)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .sel_tag_i(sel_tag_i), .unit_sel_i(unit_sel_i),
  .unit_sw_i(unit_sw_i), .cable_ok_i(cable_ok_i), .hold_n_i(hold_n_i),
  .write_gate_i(write_gate_i), .pick_i(pick_i), .pick_o(pick_o), .busy_i(busy_i),
  .busy_o(busy_o), .amf_o(amf_o), .ready_o(ready_o), .write_prot_o(write_prot_o),
  .fault_o(fault_o), .on_cyl_o(on_cyl_o), .seek_end_o(seek_end_o),
  .unit_selected_o(unit_selected_o), .motor_run_o(motor_run_o),
  .plo_servo_clk_i(plo_servo_clk_i), .servo_clk_o(servo_clk_o),
  .sep_read_clk_i(sep_read_clk_i), .read_clk_o(read_clk_o));
